// ---- cfs_core_consts.vh ----
// Constants of the CPU flag, stack and I/O space block.
// Assumes inclusion by bare name from each design file of the block.
`ifndef CFS_CORE_CONSTS_VH
`define CFS_CORE_CONSTS_VH

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define CFS_OP_W             5
`define CFS_OP_ADD           5'h00
`define CFS_OP_ADD_CARRY     5'h01
`define CFS_OP_SUB           5'h02
`define CFS_OP_SUB_CARRY     5'h03
`define CFS_OP_AND           5'h04
`define CFS_OP_OR            5'h05
`define CFS_OP_XOR           5'h06
`define CFS_OP_MOVE          5'h07
`define CFS_OP_LOAD_IMM      5'h08
`define CFS_OP_BIT_STORE     5'h09
`define CFS_OP_BIT_LOAD      5'h0A
`define CFS_OP_IRQ_ON        5'h0B
`define CFS_OP_IRQ_OFF       5'h0C
`define CFS_OP_IRQ_RETURN    5'h0D
`define CFS_OP_IO_IN         5'h0E
`define CFS_OP_IO_OUT        5'h0F
`define CFS_OP_IO_BIT_SET    5'h10
`define CFS_OP_IO_BIT_CLEAR  5'h11
`define CFS_OP_SKIP_IF_SET   5'h12
`define CFS_OP_SKIP_IF_CLR   5'h13
`define CFS_OP_DATA_LOAD     5'h14
`define CFS_OP_DATA_STORE    5'h15

// ----------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------
`define CFS_FB_IRQ_EN        7
`define CFS_FB_COPY          6
`define CFS_FB_HALF          5
`define CFS_FB_SIGN          4
`define CFS_FB_OVF           3
`define CFS_FB_NEG           2
`define CFS_FB_ZERO          1
`define CFS_FB_CARRY         0

// ----------------------------------------------------------------
// I/O space map and address ranges
// ----------------------------------------------------------------
`define CFS_IO_GP0           6'h0A
`define CFS_IO_GP1           6'h0B
`define CFS_IO_GP2           6'h0C
`define CFS_IO_NVM_LOW       6'h1E
`define CFS_IO_NVM_HIGH      6'h1F
`define CFS_IO_STACK_LOW     6'h3D
`define CFS_IO_STACK_HIGH    6'h3E
`define CFS_IO_FLAGS         6'h3F
`define CFS_IO_BIT_TOP       8'h1F
`define CFS_IO_TOP           8'h3F
`define CFS_DATA_IO_OFFSET   8'h20
`define CFS_DATA_IO_TOP      8'h5F

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CFS_TOP_OF_RAM       16'h00FF
`define CFS_FLAGS_RESET      8'h00
`define CFS_BYTE_ZERO        8'h00
`define CFS_NVM_ADDR_RESET   9'h000

`endif

// ---- cfs_alu.v ----
// Combinational arithmetic and logic unit with flag generation.
// Assumes the caller registers result and flags on the same edge.
`default_nettype none
`include "cfs_core_consts.vh"

module cfs_alu (
    input  wire [4:0] op_in,     // Operation code
    input  wire [7:0] a_in,      // Destination operand
    input  wire [7:0] b_in,      // Source operand
    input  wire [7:0] flags_in,  // Current flag register
    output reg  [7:0] res_out,   // Result
    output reg  [7:0] flags_out  // Flag register after operation
);

    wire       cin = flags_in[`CFS_FB_CARRY];
    wire [8:0] sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, cin & op_in[0]};
    wire [8:0] dif = {1'b0, a_in} - {1'b0, b_in} - {8'h00, cin & op_in[0]};

    reg  [7:0] r;
    reg        h;
    reg        v;
    reg        c;
    reg        z;

    always @* begin
        r = a_in;
        h = flags_in[`CFS_FB_HALF];
        v = 1'b0;
        c = cin;
        case (op_in)
            `CFS_OP_ADD, `CFS_OP_ADD_CARRY: begin
                r = sum[7:0];
                h = (a_in[3] & b_in[3]) | (b_in[3] & ~r[3]) | (~r[3] & a_in[3]);
                v = (a_in[7] & b_in[7] & ~r[7]) | (~a_in[7] & ~b_in[7] & r[7]);
                c = sum[8];
            end
            `CFS_OP_SUB, `CFS_OP_SUB_CARRY: begin
                r = dif[7:0];
                h = (~a_in[3] & b_in[3]) | (b_in[3] & r[3]) | (r[3] & ~a_in[3]);
                v = (a_in[7] & ~b_in[7] & ~r[7]) | (~a_in[7] & b_in[7] & r[7]);
                c = dif[8];
            end
            `CFS_OP_AND: r = a_in & b_in;
            `CFS_OP_OR:  r = a_in | b_in;
            `CFS_OP_XOR: r = a_in ^ b_in;
            default:     r = a_in;
        endcase
        // Chained subtract keeps zero only if the earlier part was zero
        if (op_in == `CFS_OP_SUB_CARRY) begin
            z = (r == `CFS_BYTE_ZERO) & flags_in[`CFS_FB_ZERO];
        end else begin
            z = (r == `CFS_BYTE_ZERO);
        end
        res_out                  = r;
        flags_out                = flags_in;
        flags_out[`CFS_FB_HALF]  = h;
        flags_out[`CFS_FB_OVF]   = v;
        flags_out[`CFS_FB_NEG]   = r[7];
        flags_out[`CFS_FB_SIGN]  = r[7] ^ v;
        flags_out[`CFS_FB_ZERO]  = z;
        flags_out[`CFS_FB_CARRY] = c;
    end

endmodule

`default_nettype wire

// ---- cfs_core_state.v ----
// CPU core state: flags, register file, stack pointer and I/O space.
// Assumes one instruction per cycle, sequenced by same-clock logic.
//
// Notes on behaviour
// - ALU operations always refresh the flag register
// - Interrupt entry and return leave flags unsaved
// - Bit 7 clear blocks every interrupt
// - Taking interrupt clears bit 7; return sets
// - Dedicated ops set and clear bit 7
// - Bit 6 copies a register bit both ways
// - Bit 5 holds low-nibble carry
// - Bit 4 equals negative xor overflow
// - Bit 3 flags two's complement overflow
// - Bit 2 set on negative result
// - Bit 1 set on zero result
// - Bit 0 holds the carry
// - CPU clock used undivided
// - Fetch, execute and write back in one cycle
// - Bit ops and skips only at 0x00-0x1F
// - In/out reach 0x00-0x3F; data space adds 0x20
// - Bit ops touch only the addressed bit
// - Three plain general purpose registers
// - Nvm write blocks reads and address changes
`default_nettype none
`include "cfs_core_consts.vh"

module cfs_core_state (
    input  wire        clk_in,        // CPU clock, used undivided
    input  wire        rst_b_in,      // Synchronous reset, active low
    input  wire        op_valid_in,   // Instruction issued this cycle
    input  wire [4:0]  op_code_in,    // Operation code
    input  wire [4:0]  rd_sel_in,     // Destination register index
    input  wire [4:0]  rr_sel_in,     // Source register index
    input  wire [7:0]  imm_in,        // Immediate value
    input  wire [2:0]  bit_sel_in,    // Bit index for bit operations
    input  wire [7:0]  addr_in,       // I/O or data-space address
    input  wire        irq_req_in,    // Enabled interrupt source pending
    input  wire        nvm_busy_in,   // Nonvolatile write in progress
    input  wire        nvm_rd_req_in, // Nonvolatile read request
    input  wire [4:0]  dbg_sel_in,    // Register file observe index
    output reg  [7:0]  flags_out,     // Flag register
    output reg  [15:0] sp_out,        // Stack pointer
    output reg  [8:0]  nvm_addr_out,  // Nonvolatile address
    output reg         nvm_rd_en_out, // Nonvolatile read strobe
    output reg         irq_ack_out,   // Interrupt taken pulse
    output reg         skip_out,      // Skip next instruction pulse
    output reg  [7:0]  rd_data_out,   // Register file observe data
    output reg  [7:0]  io_rd_out      // Data read by in/load
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg  [7:0] flags_r;
    reg  [7:0] sp_low_r;
    reg  [7:0] sp_high_r;
    reg  [7:0] gp0_r;
    reg  [7:0] gp1_r;
    reg  [7:0] gp2_r;
    reg  [7:0] nvm_low_r;
    reg        nvm_high_r;
    wire [7:0] rf_r [0:31];

    wire [7:0] op_a = rf_r[rd_sel_in];
    wire [7:0] op_b = rf_r[rr_sel_in];
    wire [7:0] alu_res;
    wire [7:0] alu_flags;

    cfs_alu u_alu (
        .op_in     (op_code_in),
        .a_in      (op_a),
        .b_in      (op_b),
        .flags_in  (flags_r),
        .res_out   (alu_res),
        .flags_out (alu_flags)
    );

    // ----------------------------------------------------------------
    // I/O space read
    // ----------------------------------------------------------------
    reg  [5:0] io_addr;
    reg  [7:0] io_rd;
    reg        io_hit;
    wire [7:0] data_io_addr = addr_in - `CFS_DATA_IO_OFFSET;
    wire [15:0] top_ram     = `CFS_TOP_OF_RAM;

    always @* begin
        io_hit  = 1'b0;
        io_addr = addr_in[5:0];
        if (op_code_in == `CFS_OP_DATA_LOAD || op_code_in == `CFS_OP_DATA_STORE) begin
            io_addr = data_io_addr[5:0];
            io_hit  = (addr_in >= `CFS_DATA_IO_OFFSET) && (addr_in <= `CFS_DATA_IO_TOP);
        end else begin
            io_hit  = (addr_in <= `CFS_IO_TOP);
        end
        case (io_addr)
            `CFS_IO_GP0:        io_rd = gp0_r;
            `CFS_IO_GP1:        io_rd = gp1_r;
            `CFS_IO_GP2:        io_rd = gp2_r;
            `CFS_IO_NVM_LOW:    io_rd = nvm_low_r;
            `CFS_IO_NVM_HIGH:   io_rd = {7'h00, nvm_high_r};
            `CFS_IO_STACK_LOW:  io_rd = sp_low_r;
            `CFS_IO_STACK_HIGH: io_rd = sp_high_r;
            `CFS_IO_FLAGS:      io_rd = flags_r;
            default:            io_rd = `CFS_BYTE_ZERO;
        endcase
    end

    // ----------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------
    reg        rf_we;
    reg  [7:0] rf_wdata;
    reg        io_we;
    reg  [7:0] io_wdata;
    reg  [7:0] flags_nxt;
    reg        skip_nxt;
    reg        ack_nxt;
    reg        io_rd_we;
    wire       bit_ok = (addr_in <= `CFS_IO_BIT_TOP);
    wire [7:0] bit_mask = 8'h01 << bit_sel_in;

    always @* begin
        rf_we     = 1'b0;
        rf_wdata  = alu_res;
        io_we     = 1'b0;
        io_wdata  = op_a;
        flags_nxt = flags_r;
        skip_nxt  = 1'b0;
        ack_nxt   = 1'b0;
        io_rd_we  = 1'b0;
        if (op_valid_in) begin
            case (op_code_in)
                `CFS_OP_ADD, `CFS_OP_ADD_CARRY, `CFS_OP_SUB, `CFS_OP_SUB_CARRY,
                `CFS_OP_AND, `CFS_OP_OR, `CFS_OP_XOR: begin
                    rf_we     = 1'b1;
                    flags_nxt = alu_flags;
                end
                `CFS_OP_MOVE: begin
                    rf_we    = 1'b1;
                    rf_wdata = op_b;
                end
                `CFS_OP_LOAD_IMM: begin
                    rf_we    = 1'b1;
                    rf_wdata = imm_in;
                end
                `CFS_OP_BIT_STORE: begin
                    flags_nxt[`CFS_FB_COPY] = op_a[bit_sel_in];
                end
                `CFS_OP_BIT_LOAD: begin
                    rf_we    = 1'b1;
                    rf_wdata = flags_r[`CFS_FB_COPY] ? (op_a | bit_mask)
                                                     : (op_a & ~bit_mask);
                end
                `CFS_OP_IRQ_ON:     flags_nxt[`CFS_FB_IRQ_EN] = 1'b1;
                `CFS_OP_IRQ_OFF:    flags_nxt[`CFS_FB_IRQ_EN] = 1'b0;
                `CFS_OP_IRQ_RETURN: flags_nxt[`CFS_FB_IRQ_EN] = 1'b1;
                `CFS_OP_IO_IN, `CFS_OP_DATA_LOAD: begin
                    rf_we    = io_hit;
                    rf_wdata = io_rd;
                    io_rd_we = io_hit;
                end
                `CFS_OP_IO_OUT, `CFS_OP_DATA_STORE: begin
                    io_we = io_hit;
                end
                `CFS_OP_IO_BIT_SET: begin
                    io_we    = bit_ok;
                    io_wdata = io_rd | bit_mask;
                end
                `CFS_OP_IO_BIT_CLEAR: begin
                    io_we    = bit_ok;
                    io_wdata = io_rd & ~bit_mask;
                end
                `CFS_OP_SKIP_IF_SET: skip_nxt = bit_ok & io_rd[bit_sel_in];
                `CFS_OP_SKIP_IF_CLR: skip_nxt = bit_ok & ~io_rd[bit_sel_in];
                default: rf_we = 1'b0;
            endcase
            if (io_we && io_addr == `CFS_IO_FLAGS) begin
                flags_nxt = io_wdata;
            end
        end else if (irq_req_in && flags_r[`CFS_FB_IRQ_EN]) begin
            // Only the enable bit changes; the rest is software's to save
            ack_nxt                   = 1'b1;
            flags_nxt[`CFS_FB_IRQ_EN] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register file, one flop group per entry
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_rf
            reg [7:0] ent_r;
            always @(posedge clk_in) begin
                if (!rst_b_in) begin
                    ent_r <= `CFS_BYTE_ZERO;
                end else if (rf_we && rd_sel_in == gi) begin
                    ent_r <= rf_wdata;
                end
            end
            assign rf_r[gi] = ent_r;
        end
    endgenerate

    // ----------------------------------------------------------------
    // I/O registers and outputs
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            flags_r    <= `CFS_FLAGS_RESET;
            sp_low_r   <= top_ram[7:0];
            sp_high_r  <= top_ram[15:8];
            gp0_r      <= `CFS_BYTE_ZERO;
            gp1_r      <= `CFS_BYTE_ZERO;
            gp2_r      <= `CFS_BYTE_ZERO;
            nvm_low_r  <= `CFS_BYTE_ZERO;
            nvm_high_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            if (io_we) begin
                case (io_addr)
                    `CFS_IO_GP0:        gp0_r     <= io_wdata;
                    `CFS_IO_GP1:        gp1_r     <= io_wdata;
                    `CFS_IO_GP2:        gp2_r     <= io_wdata;
                    `CFS_IO_STACK_LOW:  sp_low_r  <= io_wdata;
                    `CFS_IO_STACK_HIGH: sp_high_r <= io_wdata;
                    `CFS_IO_NVM_LOW: begin
                        if (!nvm_busy_in) nvm_low_r <= io_wdata;
                    end
                    `CFS_IO_NVM_HIGH: begin
                        if (!nvm_busy_in) nvm_high_r <= io_wdata[0];
                    end
                    default: gp0_r <= gp0_r;
                endcase
            end
        end
    end

    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            flags_out     <= `CFS_FLAGS_RESET;
            sp_out        <= `CFS_TOP_OF_RAM;
            nvm_addr_out  <= `CFS_NVM_ADDR_RESET;
            nvm_rd_en_out <= 1'b0;
            irq_ack_out   <= 1'b0;
            skip_out      <= 1'b0;
            rd_data_out   <= `CFS_BYTE_ZERO;
            io_rd_out     <= `CFS_BYTE_ZERO;
        end else begin
            flags_out     <= flags_nxt;
            sp_out        <= {sp_high_r, sp_low_r};
            nvm_addr_out  <= {nvm_high_r, nvm_low_r};
            nvm_rd_en_out <= nvm_rd_req_in & ~nvm_busy_in;
            irq_ack_out   <= ack_nxt;
            skip_out      <= skip_nxt;
            rd_data_out   <= rf_r[dbg_sel_in];
            if (io_rd_we) begin
                io_rd_out <= io_rd;
            end
        end
    end

endmodule

`default_nettype wire

// ---- cfs_core_monitor.sv ----
// Checker of the core state block's port relations.
// Assumes a bind onto cfs_core_state from the bench.
`default_nettype none
`include "cfs_core_consts.vh"
module cfs_core_monitor (
    input wire logic        clk_in,        // Clock
    input wire logic        rst_b_in,      // Reset, low
    input wire logic        op_valid_in,   // Op issued
    input wire logic [4:0]  op_code_in,    // Op code
    input wire logic [7:0]  addr_in,       // Address
    input wire logic        irq_req_in,    // Irq pending
    input wire logic        nvm_busy_in,   // Nvm busy
    input wire logic        nvm_rd_req_in, // Nvm read request
    input wire logic [7:0]  flags_out,     // Flags
    input wire logic [15:0] sp_out,        // Stack pointer
    input wire logic [8:0]  nvm_addr_out,  // Nvm address
    input wire logic        nvm_rd_en_out, // Nvm read strobe
    input wire logic        irq_ack_out,   // Irq taken
    input wire logic        skip_out       // Skip pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic skip_op = op_valid_in && (op_code_in == `CFS_OP_SKIP_IF_SET
        || op_code_in == `CFS_OP_SKIP_IF_CLR);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking mcb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);
    sequence irq_due_s;
        !op_valid_in && irq_req_in && flags_out[7];
    endsequence
    sequence irq_done_s;
        irq_ack_out && !flags_out[7];
    endsequence
    irq_take_a: assert property (irq_due_s |=> irq_done_s)
        else $error("interrupt not taken");
    irq_gate_a: assert property (!flags_out[7] |=> !irq_ack_out)
        else $error("interrupt taken while disabled");
    irq_busy_a: assert property (op_valid_in |=> !irq_ack_out)
        else $error("interrupt taken during an op");
    irq_return_a: assert property (op_valid_in && op_code_in == `CFS_OP_IRQ_RETURN
        |=> flags_out[7]) else $error("return left irq disabled");
    irq_on_a: assert property (op_valid_in && op_code_in == `CFS_OP_IRQ_ON
        |=> flags_out[7]) else $error("irq enable op failed");
    irq_off_a: assert property (op_valid_in && op_code_in == `CFS_OP_IRQ_OFF
        |=> !flags_out[7]) else $error("irq disable op failed");
    sign_bit_a: assert property (op_valid_in && op_code_in <= `CFS_OP_XOR
        |=> flags_out[4] == (flags_out[2] ^ flags_out[3])) else $error("sign bit wrong");
    skip_range_a: assert property (skip_op && addr_in > `CFS_IO_BIT_TOP
        |=> !skip_out) else $error("skip above bit range");
    skip_cause_a: assert property (!skip_op |=> !skip_out)
        else $error("skip without a skip op");
    nvm_read_a: assert property (nvm_rd_en_out
        |-> $past(nvm_rd_req_in) && !$past(nvm_busy_in)) else $error("nvm read while busy");
    nvm_hold_a: assert property (nvm_busy_in |=> ##1 $stable(nvm_addr_out))
        else $error("nvm address changed while busy");
    sp_reset_a: assert property (disable iff (1'b0) !rst_b_in ##1 !rst_b_in
        |-> sp_out == `CFS_TOP_OF_RAM && flags_out == `CFS_FLAGS_RESET)
        else $error("reset values wrong");
endmodule
`default_nettype wire

// ---- test_cpu_status_stack_io_space.sv ----
// Self-checking bench of the core state block.
// Assumes cfs_core_state, cfs_core_monitor and the constant header.
`default_nettype none
`include "cfs_core_consts.vh"
module test_cpu_status_stack_io_space;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {int due; int sel; logic [15:0] exp;} cfs_note_t;
    logic        clk_in, rst_b_in, op_valid_in, irq_req_in, nvm_busy_in, nvm_rd_req_in;
    logic [4:0]  op_code_in, rd_sel_in, rr_sel_in, dbg_sel_in, prev_rd;
    logic [7:0]  imm_in, addr_in, flags_out, rd_data_out, io_rd_out, fl;
    logic [2:0]  bit_sel_in;
    logic [15:0] sp_out;
    logic [8:0]  nvm_addr_out;
    logic        nvm_rd_en_out, irq_ack_out, skip_out, irq_nxt;
    logic [7:0]  m_rf [32];
    logic [31:0] seed = 32'h20471945;
    int          cyc = 0, failures = 0, num_checks = 0;
    cfs_note_t   q [$];
    string       nm [8] = '{"flags", "io_rd", "skip", "irq_ack", "rd_data", "sp",
                            "nvm_rd_en", "nvm_addr"};
    cfs_core_state uut (.clk_in, .rst_b_in, .op_valid_in, .op_code_in, .rd_sel_in,
        .rr_sel_in, .imm_in, .bit_sel_in, .addr_in, .irq_req_in, .nvm_busy_in,
        .nvm_rd_req_in, .dbg_sel_in, .flags_out, .sp_out, .nvm_addr_out, .nvm_rd_en_out,
        .irq_ack_out, .skip_out, .rd_data_out, .io_rd_out);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] obs(int s);
        case (s)
            0: return {8'h00, flags_out};
            1: return {8'h00, io_rd_out};
            2: return {15'h0000, skip_out};
            3: return {15'h0000, irq_ack_out};
            4: return {8'h00, rd_data_out};
            5: return sp_out;
            6: return {15'h0000, nvm_rd_en_out};
            default: return {7'h00, nvm_addr_out};
        endcase
    endfunction
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic note(int s, logic [15:0] v, int lag);
        q.push_back('{cyc + lag, s, v});
    endtask
    task automatic issue(logic v, logic [4:0] c, logic [4:0] d, logic [4:0] r,
                         logic [7:0] i, logic [2:0] b, logic [7:0] a);
        @(negedge clk_in);
        op_valid_in = v;
        op_code_in = c;
        rd_sel_in = d;
        rr_sel_in = r;
        imm_in = i;
        bit_sel_in = b;
        addr_in = a;
        dbg_sel_in = prev_rd;
        irq_req_in = irq_nxt;
    endtask
    // Issues one op and predicts flags, register and interrupt outcome
    task automatic alu(logic v, logic [4:0] c, logic [4:0] d, logic [4:0] r,
                       logic [7:0] i, logic [2:0] b);
        logic [8:0] s;
        logic [7:0] x, y, res;
        logic       cin;
        x = m_rf[d];
        y = m_rf[r];
        res = x;
        cin = fl[0] && (c == `CFS_OP_ADD_CARRY || c == `CFS_OP_SUB_CARRY);
        issue(v, c, d, r, i, b, 8'h00);
        note(4, {8'h00, m_rf[prev_rd]}, 1);
        if (!v) begin
            note(3, {15'h0000, irq_nxt && fl[7]}, 1);
            fl[7] = fl[7] && !irq_nxt;
        end else case (c)
            `CFS_OP_ADD, `CFS_OP_ADD_CARRY: begin
                s = x + y + cin;
                res = s[7:0];
                fl[5] = (int'(x[3:0]) + int'(y[3:0]) + int'(cin)) > 15;
                fl[3] = x[7] == y[7] && res[7] != x[7];
                fl[0] = s[8];
            end
            `CFS_OP_SUB, `CFS_OP_SUB_CARRY: begin
                s = {1'b0, x} - y - cin;
                res = s[7:0];
                fl[5] = int'(x[3:0]) < int'(y[3:0]) + int'(cin);
                fl[3] = x[7] != y[7] && res[7] != x[7];
                fl[0] = s[8];
            end
            `CFS_OP_AND: res = x & y;
            `CFS_OP_OR: res = x | y;
            `CFS_OP_XOR: res = x ^ y;
            `CFS_OP_MOVE: res = y;
            `CFS_OP_LOAD_IMM: res = i;
            `CFS_OP_BIT_STORE: fl[6] = x[b];
            `CFS_OP_BIT_LOAD: res[b] = fl[6];
            `CFS_OP_IRQ_OFF: fl[7] = 1'b0;
            default: fl[7] = 1'b1;
        endcase
        if (v && c <= `CFS_OP_XOR) begin
            if (c >= `CFS_OP_AND)
                fl[3] = 1'b0;
            fl[2] = res[7];
            fl[1] = res == 8'h00 && (c != `CFS_OP_SUB_CARRY || fl[1]);
            fl[4] = fl[2] ^ fl[3];
        end
        m_rf[d] = res;
        note(0, {8'h00, fl}, 1);
        prev_rd = d;
    endtask
    task automatic io(logic [4:0] c, logic [4:0] r, logic [7:0] a, logic [2:0] b);
        issue(1'b1, c, r, r, 8'h00, b, a);
    endtask
    task automatic put(logic [7:0] a, logic [7:0] v);
        alu(1'b1, `CFS_OP_LOAD_IMM, 5'h03, 5'h00, v, 3'h0);
        io(`CFS_OP_IO_OUT, 5'h03, a, 3'h0);
    endtask
    task automatic get(logic [7:0] a, logic [7:0] v);
        io(`CFS_OP_IO_IN, 5'h04, a, 3'h0);
        note(1, {8'h00, v}, 1);
    endtask
    // ----------------------------------------
    // Clock and result watcher
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        forever begin
            @(posedge clk_in);
            cyc++;
            #1;
            while (q.size() > 0 && q[0].due <= cyc) begin
                num_checks++;
                if (obs(q[0].sel) !== q[0].exp) begin
                    failures++;
                    $display("ERROR %s expected %h seen %h", nm[q[0].sel], q[0].exp,
                             obs(q[0].sel));
                end
                void'(q.pop_front());
            end
            if (cyc > 2000) begin
                failures++;
                complete_run();
            end
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] w;
        {rst_b_in, op_valid_in, irq_req_in, nvm_busy_in, nvm_rd_req_in, irq_nxt} = 6'h00;
        {op_code_in, rd_sel_in, rr_sel_in, dbg_sel_in, prev_rd} = 25'h0000000;
        {imm_in, addr_in, fl, bit_sel_in} = 27'h0000000;
        foreach (m_rf[k])
            m_rf[k] = 8'h00;
        repeat (6) @(negedge clk_in);
        rst_b_in = 1'b1;
        alu(1'b0, 5'h00, 5'h00, 5'h00, 8'h00, 3'h0);
        note(5, `CFS_TOP_OF_RAM, 1);
        $display("test reset done");
        for (int k = 0; k < 400; k++) begin
            w = rnd();
            irq_nxt = w[27];
            alu(|w[26:25], {1'b0, w[3:0] % 4'hE}, w[8:4], w[13:9], w[21:14], w[24:22]);
        end
        irq_nxt = 1'b0;
        $display("test alu done");
        for (int g = 0; g < 3; g++) begin
            put(8'h0A + 8'(g), 8'hA5 ^ 8'(g));
            get(8'h0A + 8'(g), 8'hA5 ^ 8'(g));
        end
        io(`CFS_OP_IO_BIT_CLEAR, 5'h04, 8'h0A, 3'h0);
        io(`CFS_OP_IO_BIT_SET, 5'h04, 8'h0A, 3'h1);
        get(8'h0A, 8'hA6);
        io(`CFS_OP_SKIP_IF_SET, 5'h04, 8'h0A, 3'h1);
        note(2, 16'h0001, 1);
        io(`CFS_OP_SKIP_IF_CLR, 5'h04, 8'h0A, 3'h1);
        note(2, 16'h0000, 1);
        io(`CFS_OP_SKIP_IF_CLR, 5'h04, 8'h0A, 3'h0);
        note(2, 16'h0001, 1);
        io(fl[7] ? `CFS_OP_SKIP_IF_SET : `CFS_OP_SKIP_IF_CLR, 5'h04, 8'h3F, 3'h7);
        note(2, 16'h0000, 1);
        io(fl[7] ? `CFS_OP_IO_BIT_CLEAR : `CFS_OP_IO_BIT_SET, 5'h04, 8'h3F, 3'h7);
        note(0, {8'h00, fl}, 1);
        io(`CFS_OP_DATA_LOAD, 5'h04, 8'h2A, 3'h0);
        note(1, 16'h00A6, 1);
        io(`CFS_OP_DATA_STORE, 5'h03, 8'h2B, 3'h0);
        get(8'h0B, 8'hA7);
        get(8'h3D, 8'hFF);
        get(8'h3E, 8'h00);
        put(8'h3D, 8'h34);
        put(8'h3E, 8'h12);
        note(5, 16'h1234, 2);
        put(8'h1E, 8'h5A);
        put(8'h1F, 8'h01);
        note(7, 16'h015A, 2);
        get(8'h1F, 8'h01);
        nvm_busy_in = 1'b1;
        put(8'h1E, 8'h00);
        nvm_rd_req_in = 1'b1;
        note(6, 16'h0000, 1);
        note(7, 16'h015A, 2);
        issue(1'b0, 5'h00, 5'h00, 5'h00, 8'h00, 3'h0, 8'h00);
        nvm_busy_in = 1'b0;
        note(6, 16'h0001, 1);
        issue(1'b0, 5'h00, 5'h00, 5'h00, 8'h00, 3'h0, 8'h00);
        nvm_rd_req_in = 1'b0;
        repeat (3) @(negedge clk_in);
        $display("test io done");
        complete_run();
    end
endmodule
bind cfs_core_state cfs_core_monitor mon (.clk_in, .rst_b_in, .op_valid_in, .op_code_in,
    .addr_in, .irq_req_in, .nvm_busy_in, .nvm_rd_req_in, .flags_out, .sp_out,
    .nvm_addr_out, .nvm_rd_en_out, .irq_ack_out, .skip_out);
`default_nettype wire
